// [dv/avfr_chk_asserts.sv]
// port-level checks of the auxiliary fault reaction block
// assumes it is bound to the top module and sees its ports only
`timescale 1ns/1ns
module avfr_chk
  import avfr_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic CMD_VALID,
  input wire logic CMD_WRITE,
  input wire logic [7:0] CMD_CODE,
  input wire logic CMD_CLEAR_FAULTS,
  input wire logic [15:0] RD_DATA,
  input wire logic RD_VALID,
  input wire logic CMD_ERR,
  input wire logic ENABLE_CMD,
  input wire logic BIAS_OK,
  input wire logic OTHER_FAULT,
  input wire logic OUTPUT_EN,
  input wire logic ALERT_OUTPUT_B,
  input wire logic STATUS_OV_FAULT,
  input wire logic STATUS_UV_FAULT
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_B);
  logic known;
  // codes that the block answers
  assign known = CMD_CODE inside {AVFR_CODE_READING, AVFR_CODE_OV_REACT,
    AVFR_CODE_UV_REACT};

  sequence s_read_req;
    CMD_VALID && !CMD_WRITE && known;
  endsequence
  sequence s_bad_req;
    CMD_VALID && (!known || (CMD_WRITE && CMD_CODE == AVFR_CODE_READING));
  endsequence
  property p_read_ans;
    s_read_req |=> RD_VALID && !CMD_ERR;
  endproperty
  property p_bad_ans;
    s_bad_req |=> CMD_ERR && !RD_VALID;
  endproperty
  property p_idle;
    !CMD_VALID |=> !RD_VALID && !CMD_ERR;
  endproperty
  property p_rd_hold;
    !RD_VALID |-> $stable(RD_DATA);
  endproperty
  property p_alert;
    ALERT_OUTPUT_B == !(STATUS_OV_FAULT || STATUS_UV_FAULT);
  endproperty
  property p_ov_sticky;
    STATUS_OV_FAULT && !CMD_CLEAR_FAULTS |=> STATUS_OV_FAULT;
  endproperty
  property p_uv_sticky;
    STATUS_UV_FAULT && !CMD_CLEAR_FAULTS |=> STATUS_UV_FAULT;
  endproperty
  property p_stop;
    !ENABLE_CMD || !BIAS_OK || OTHER_FAULT |=> !OUTPUT_EN;
  endproperty

  a_read_ans: assert property (p_read_ans)
    else $error("read not answered");
  a_bad_ans: assert property (p_bad_ans)
    else $error("bad command not refused");
  a_idle: assert property (p_idle)
    else $error("answer without command");
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved");
  a_alert: assert property (p_alert)
    else $error("alert differs from fault bits");
  a_ov_sticky: assert property (p_ov_sticky)
    else $error("ov fault bit lost");
  a_uv_sticky: assert property (p_uv_sticky)
    else $error("uv fault bit lost");
  a_stop: assert property (p_stop)
    else $error("output on while stopped");
endmodule

bind avfr_top avfr_chk u_chk (
  .REF_CLK(REF_CLK), .RST_B(RST_B), .CMD_VALID(CMD_VALID),
  .CMD_WRITE(CMD_WRITE), .CMD_CODE(CMD_CODE),
  .CMD_CLEAR_FAULTS(CMD_CLEAR_FAULTS), .RD_DATA(RD_DATA),
  .RD_VALID(RD_VALID), .CMD_ERR(CMD_ERR), .ENABLE_CMD(ENABLE_CMD),
  .BIAS_OK(BIAS_OK), .OTHER_FAULT(OTHER_FAULT), .OUTPUT_EN(OUTPUT_EN),
  .ALERT_OUTPUT_B(ALERT_OUTPUT_B), .STATUS_OV_FAULT(STATUS_OV_FAULT),
  .STATUS_UV_FAULT(STATUS_UV_FAULT));

// [dv/avfr_host.sv]
// host model of the command port: reads, writes and clear-faults
// assumes requests launch one unit delay after a rising REF_CLK edge
`timescale 1ns/1ns
module avfr_host (
  input wire logic clk,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic cmd_err,
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [7:0] cmd_wdata,
  output logic clear_faults
);
  // idle port at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 8'h00;
    clear_faults = 1'b0;
  end

  // one command; code and data go stale so a late sample is caught
  task automatic xfer(input logic w, input logic [7:0] c,
      input logic [7:0] wd, output logic [15:0] d, output logic [1:0] e);
    @(posedge clk);
    #1 cmd_valid = 1'b1;
    cmd_write = w;
    cmd_code = c;
    cmd_wdata = wd;
    @(posedge clk);
    #1 cmd_valid = 1'b0;
    cmd_code = ~c;
    cmd_wdata = ~wd;
    // the answer stands only in the cycle after the taking edge
    d = rd_data;
    e = {rd_valid, cmd_err};
  endtask

  // clear-faults strobe, one cycle
  task automatic clear();
    @(posedge clk);
    #1 clear_faults = 1'b1;
    @(posedge clk);
    #1 clear_faults = 1'b0;
  endtask
endmodule

// [dv/avfr_tb.sv]
// self-checking bench of the auxiliary fault reaction block
// assumes the host model drives the command port
`timescale 1ns/1ns
module testbench;
  localparam int RC = 8;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic sv = 1'b0, en = 1'b1, bias = 1'b1, oth = 1'b0;
  logic [15:0] pin = 16'h0000;
  logic [19:0] ovl = 20'hfffff, uvl = 20'h00000;
  logic cv, cw, cf, rv, ce, oe, al_b, sov, suv, wov, wuv;
  logic [7:0] cc, cd;
  logic [15:0] rdd, d;
  logic [1:0] e;
  int n_fail = 0, cmp_count = 0, n;

  always #20 clk = ~clk;

  avfr_top #(.RETRY_CYCLES(RC)) uut (.REF_CLK(clk), .RST_B(rst_b),
    .CMD_VALID(cv), .CMD_WRITE(cw), .CMD_CODE(cc), .CMD_WDATA(cd),
    .CMD_CLEAR_FAULTS(cf), .RD_DATA(rdd), .RD_VALID(rv), .CMD_ERR(ce),
    .AUX_SAMPLE_VALID(sv), .AUX_PIN_CODE(pin), .OV_FAULT_LIMIT(ovl),
    .UV_FAULT_LIMIT(uvl), .ENABLE_CMD(en), .BIAS_OK(bias),
    .OTHER_FAULT(oth), .OUTPUT_EN(oe), .ALERT_OUTPUT_B(al_b),
    .STATUS_OV_FAULT(sov), .STATUS_UV_FAULT(suv),
    .STATUS_OV_WARN(wov), .STATUS_UV_WARN(wuv));
  avfr_host host (.clk(clk), .rd_data(rdd), .rd_valid(rv),
    .cmd_err(ce), .cmd_valid(cv), .cmd_write(cw), .cmd_code(cc),
    .cmd_wdata(cd), .clear_faults(cf));

  task automatic chk(string nm, logic [15:0] got, logic [15:0] x);
    cmp_count++;
    if (got !== x) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, x, got);
    end
  endtask
  // read answers with the valid flag only
  task automatic rd(logic [7:0] c, logic [15:0] x);
    host.xfer(1'b0, c, 8'h00, d, e);
    chk("read data", d, x);
    chk("read flags", e, 16'h2);
  endtask
  task automatic wr(logic [7:0] c, logic [7:0] v, logic [1:0] x);
    host.xfer(1'b1, c, v, d, e);
    chk("write flags", e, x);
  endtask
  // fault flags, alert and enable seen together
  task automatic stat(logic [3:0] x);
    #1 chk("status", {sov, suv, al_b, oe}, x);
  endtask
  // pin code is scrambled off the strobe so stale use shows
  task automatic samp(logic [15:0] v);
    @(posedge clk);
    #1 sv = 1'b1;
    pin = v;
    @(posedge clk);
    #1 sv = 1'b0;
    pin = ~v;
    @(posedge clk);
    #1;
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    #1 rst_b = 1'b1;
    rd(8'hf8, 16'h0080);
    rd(8'hf9, 16'h0080);
    rd(8'hf7, 16'h0000);
    wr(8'hf7, 8'h12, 2'b01);
    wr(8'hfa, 8'h12, 2'b01);
    wr(8'hf8, 8'hc7, 2'b00);
    wr(8'hf9, 8'h5a, 2'b00);
    rd(8'hf8, 16'h00c7);
    rd(8'hf9, 16'h005a);
    samp(16'h0100);
    rd(8'hf7, 16'hba00);
    stat(4'b0011);
    // move the sample into the window before the limits tighten
    samp(16'h1000);
    rd(8'hf7, 16'hda00);
    ovl = 20'h20000;
    uvl = 20'h08000;
    // warning thresholds at the boundary codes
    samp(16'h1ccc);
    chk("ov warn", wov, 16'h0);
    samp(16'h1ccd);
    chk("ov warn", {wov, sov}, 16'h2);
    samp(16'h08cd);
    chk("uv warn", wuv, 16'h0);
    samp(16'h08cc);
    chk("uv warn", {wuv, suv}, 16'h2);
    samp(16'h1000);
    host.clear();
    chk("warn clear", {wov, wuv}, 16'h0);
    // latched shutdown, no retry
    wr(8'hf8, 8'h80, 2'b00);
    samp(16'h3000);
    stat(4'b1000);
    samp(16'h1000);
    stat(4'b1000);
    host.clear();
    repeat (2) @(posedge clk);
    stat(4'b0011);
    // hold off while the undervoltage lasts
    wr(8'hf9, 8'hc0, 2'b00);
    samp(16'h0400);
    stat(4'b0100);
    samp(16'h1000);
    @(posedge clk);
    stat(4'b0101);
    host.clear();
    // unused response code: flags only
    wr(8'hf9, 8'h40, 2'b00);
    samp(16'h0400);
    stat(4'b0101);
    samp(16'h1000);
    host.clear();
    // continuous retry with the fault left in place
    wr(8'hf8, 8'hb8, 2'b00);
    samp(16'h3000);
    stat(4'b1000);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (oe !== 1'b1 && n < 50);
    chk("retry gap", n[15:0], 16'(RC));
    if (n >= 50)
      end_of_test();
    @(posedge clk);
    #1 chk("retrip", oe, 16'h0);
    en = 1'b0;
    repeat (RC + 4) @(posedge clk);
    #1 chk("commanded off", oe, 16'h0);
    samp(16'h1000);
    en = 1'b1;
    host.clear();
    repeat (2) @(posedge clk);
    stat(4'b0011);
    bias = 1'b0;
    @(posedge clk);
    #1 bias = 1'b1;
    chk("bias lost off", oe, 16'h0);
    // let the output come back so the other fault alone must stop it
    @(posedge clk);
    #1 oth = 1'b1;
    chk("back on", oe, 16'h1);
    @(posedge clk);
    #1 oth = 1'b0;
    chk("other fault off", oe, 16'h0);
    rst_b = 1'b0;
    repeat (3) @(posedge clk);
    #1 rst_b = 1'b1;
    rd(8'hf8, 16'h0080);
    end_of_test();
  end
endmodule

// [hdl/avfr_lin11_enc.sv]
// linear-11 encoder: unsigned magnitude with a fixed lsb weight in,
// exponent and mantissa word out; purely combinational
// assumes the caller registers the result
`timescale 1ns/1ns
module avfr_lin11_enc
  import avfr_pkg::*;
#(
  parameter int IW = 20,
  parameter int BASE_EXP = AVFR_PIN_EXP
) (
  input wire logic [IW-1:0] value,
  output logic [15:0] word
);

  logic [IW-1:0] v;
  int e;

  // halve until the mantissa fits; truncation loses at most one lsb
  always_comb begin
    v = value;
    e = BASE_EXP;
    for (int i = 0; i < IW; i++) begin
      if (v >= IW'(AVFR_MANT_LIMIT)) begin
        v = v >> 1;
        e = e + 1;
      end
    end
    word = {e[AVFR_EXP_W-1:0], v[AVFR_MANT_W-1:0]};
  end

endmodule

// [hdl/avfr_top.sv]
// auxiliary monitor voltage readback and fault reaction logic
// assumes command strobes, samples and limits are synchronous to REF_CLK
// and that the limits are given in the same units as the sample
`timescale 1ns/1ns
module avfr_top
  import avfr_pkg::*;
#(
  parameter int RETRY_CYCLES = AVFR_RETRY_UNIT_CYCLES,
  parameter int PW = 16
) (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic CMD_VALID,
  input wire logic CMD_WRITE,
  input wire logic [7:0] CMD_CODE,
  input wire logic [7:0] CMD_WDATA,
  input wire logic CMD_CLEAR_FAULTS,
  output logic [15:0] RD_DATA,
  output logic RD_VALID,
  output logic CMD_ERR,
  input wire logic AUX_SAMPLE_VALID,
  input wire logic [PW-1:0] AUX_PIN_CODE,
  input wire logic [PW+3:0] OV_FAULT_LIMIT,
  input wire logic [PW+3:0] UV_FAULT_LIMIT,
  input wire logic ENABLE_CMD,
  input wire logic BIAS_OK,
  input wire logic OTHER_FAULT,
  output logic OUTPUT_EN,
  output logic ALERT_OUTPUT_B,
  output logic STATUS_OV_FAULT,
  output logic STATUS_UV_FAULT,
  output logic STATUS_OV_WARN,
  output logic STATUS_UV_WARN
);

  localparam int QW = PW + AVFR_PIN_GAIN_SHIFT;
  localparam int CW = $clog2(RETRY_CYCLES + 1);
  localparam int WW = QW + 4;

  // sample path state
  logic [QW-1:0] quant_r, quant_nxt;
  logic seen_r, seen_nxt;
  logic [15:0] reading_r, reading_nxt;
  logic [15:0] enc_word;
  logic [QW-1:0] pin_scaled;

  // command path state
  logic [7:0] ov_react_r, ov_react_nxt;
  logic [7:0] uv_react_r, uv_react_nxt;
  logic [15:0] rd_data_r, rd_data_nxt;
  logic rd_valid_r, rd_valid_nxt;
  logic err_r, err_nxt;

  // status state
  logic ov_flag_r, ov_flag_nxt;
  logic uv_flag_r, uv_flag_nxt;
  logic ovw_flag_r, ovw_flag_nxt;
  logic uvw_flag_r, uvw_flag_nxt;
  logic alert_b_r, alert_b_nxt;

  // output control state
  avfr_state_t st_r, st_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic out_en_r, out_en_nxt;

  // comparisons
  logic [WW-1:0] ov_warn_lim, uv_warn_lim;
  logic ov_now, uv_now, ovw_now, uvw_now, fault_now, run_ok;
  logic [7:0] act_react;

  // scale pin code to the monitored quantity
  assign pin_scaled = {AUX_PIN_CODE, 4'h0};

  avfr_lin11_enc #(
    .IW(QW),
    .BASE_EXP(AVFR_PIN_EXP)
  ) u_enc (
    .value(pin_scaled),
    .word(enc_word)
  );

  // capture each new sample; faults are judged only once one has arrived,
  // otherwise the zero reset value would look like an undervoltage
  always_comb begin
    quant_nxt = quant_r;
    seen_nxt = seen_r;
    reading_nxt = reading_r;
    if (AUX_SAMPLE_VALID) begin
      quant_nxt = pin_scaled;
      seen_nxt = 1'b1;
      reading_nxt = enc_word;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      quant_r <= '0;
      seen_r <= 1'b0;
      reading_r <= AVFR_READING_RESET;
    end else begin
      quant_r <= quant_nxt;
      seen_r <= seen_nxt;
      reading_r <= reading_nxt;
    end
  end

  // warning levels follow the fault limits; constant divide kept simple
  // because limits change rarely and timing at 25 MHz is relaxed
  always_comb begin
    ov_warn_lim = WW'((WW'(OV_FAULT_LIMIT) * WW'(AVFR_OV_WARN_NUM))
                  / WW'(AVFR_WARN_DEN));
    uv_warn_lim = WW'((WW'(UV_FAULT_LIMIT) * WW'(AVFR_UV_WARN_NUM))
                  / WW'(AVFR_WARN_DEN));
    ov_now = seen_r && (quant_r > OV_FAULT_LIMIT);
    uv_now = seen_r && (quant_r < UV_FAULT_LIMIT);
    ovw_now = seen_r && (WW'(quant_r) > ov_warn_lim);
    uvw_now = seen_r && (WW'(quant_r) < uv_warn_lim);
    fault_now = ov_now || uv_now;
    run_ok = ENABLE_CMD && BIAS_OK && !OTHER_FAULT;
    // overvoltage reaction takes priority when both faults are present
    act_react = ov_now ? ov_react_r : uv_react_r;
  end

  // command decode; reads answer one cycle later from flops
  always_comb begin
    ov_react_nxt = ov_react_r;
    uv_react_nxt = uv_react_r;
    rd_data_nxt = rd_data_r;
    rd_valid_nxt = 1'b0;
    err_nxt = 1'b0;
    if (CMD_VALID) begin
      case (CMD_CODE)
        AVFR_CODE_READING: begin
          if (CMD_WRITE) begin
            err_nxt = 1'b1;
          end else begin
            rd_data_nxt = reading_r;
            rd_valid_nxt = 1'b1;
          end
        end
        AVFR_CODE_OV_REACT: begin
          if (CMD_WRITE) begin
            ov_react_nxt = CMD_WDATA;
          end else begin
            rd_data_nxt = {8'h00, ov_react_r};
            rd_valid_nxt = 1'b1;
          end
        end
        AVFR_CODE_UV_REACT: begin
          if (CMD_WRITE) begin
            uv_react_nxt = CMD_WDATA;
          end else begin
            rd_data_nxt = {8'h00, uv_react_r};
            rd_valid_nxt = 1'b1;
          end
        end
        default: begin
          err_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ov_react_r <= AVFR_REACT_RESET;
      uv_react_r <= AVFR_REACT_RESET;
      rd_data_r <= 16'h0000;
      rd_valid_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      ov_react_r <= ov_react_nxt;
      uv_react_r <= uv_react_nxt;
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
      err_r <= err_nxt;
    end
  end

  // sticky status: a fault present in the clearing cycle keeps its bit
  always_comb begin
    ov_flag_nxt = ov_now || (ov_flag_r && !CMD_CLEAR_FAULTS);
    uv_flag_nxt = uv_now || (uv_flag_r && !CMD_CLEAR_FAULTS);
    ovw_flag_nxt = ovw_now || (ovw_flag_r && !CMD_CLEAR_FAULTS);
    uvw_flag_nxt = uvw_now || (uvw_flag_r && !CMD_CLEAR_FAULTS);
    alert_b_nxt = !(ov_flag_nxt || uv_flag_nxt);
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ov_flag_r <= 1'b0;
      uv_flag_r <= 1'b0;
      ovw_flag_r <= 1'b0;
      uvw_flag_r <= 1'b0;
      alert_b_r <= 1'b1;
    end else begin
      ov_flag_r <= ov_flag_nxt;
      uv_flag_r <= uv_flag_nxt;
      ovw_flag_r <= ovw_flag_nxt;
      uvw_flag_r <= uvw_flag_nxt;
      alert_b_r <= alert_b_nxt;
    end
  end

  // output control; response codes 00/01, and retry codes 001-110 under response 10,
  // take no action on the output, only alert and status
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      AVFR_ST_STOP: begin
        if (run_ok) begin
          st_nxt = AVFR_ST_RUN;
        end
      end
      AVFR_ST_RUN: begin
        if (!run_ok) begin
          st_nxt = AVFR_ST_STOP;
        end else if (fault_now && act_react[AVFR_RESP_HI:AVFR_RESP_LO]
                     == AVFR_RESP_SHUTDOWN) begin
          if (act_react[AVFR_RETRY_HI:AVFR_RETRY_LO] == AVFR_RETRY_CONT) begin
            st_nxt = AVFR_ST_RETRY;
            cnt_nxt = '0;
          end else if (act_react[AVFR_RETRY_HI:AVFR_RETRY_LO]
                       == AVFR_RETRY_NONE) begin
            st_nxt = AVFR_ST_LATCH;
          end
        end else if (fault_now && act_react[AVFR_RESP_HI:AVFR_RESP_LO]
                     == AVFR_RESP_HOLD) begin
          st_nxt = AVFR_ST_HOLD;
        end
      end
      AVFR_ST_LATCH: begin
        if (!run_ok) begin
          st_nxt = AVFR_ST_STOP;
        end else if (CMD_CLEAR_FAULTS) begin
          st_nxt = AVFR_ST_RUN;
        end
      end
      AVFR_ST_HOLD: begin
        if (!run_ok) begin
          st_nxt = AVFR_ST_STOP;
        end else if (!fault_now) begin
          st_nxt = AVFR_ST_RUN;
        end
      end
      AVFR_ST_RETRY: begin
        // the restart does not look at the fault; a lasting fault simply
        // shuts the output down again from the run state
        if (!run_ok) begin
          st_nxt = AVFR_ST_STOP;
        end else if (cnt_r == CW'(RETRY_CYCLES - 1)) begin
          st_nxt = AVFR_ST_RUN;
          cnt_nxt = '0;
        end else begin
          cnt_nxt = cnt_r + CW'(1);
        end
      end
      default: begin
        st_nxt = AVFR_ST_STOP;
      end
    endcase
    out_en_nxt = (st_nxt == AVFR_ST_RUN);
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_r <= AVFR_ST_STOP;
      cnt_r <= '0;
      out_en_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      out_en_r <= out_en_nxt;
    end
  end

  assign RD_DATA = rd_data_r;
  assign RD_VALID = rd_valid_r;
  assign CMD_ERR = err_r;
  assign OUTPUT_EN = out_en_r;
  assign ALERT_OUTPUT_B = alert_b_r;
  assign STATUS_OV_FAULT = ov_flag_r;
  assign STATUS_UV_FAULT = uv_flag_r;
  assign STATUS_OV_WARN = ovw_flag_r;
  assign STATUS_UV_WARN = uvw_flag_r;

endmodule

// [shared/avfr_pkg.sv]
// constants, register codes and state encoding of the auxiliary voltage
// fault response block; shared by the top module and the encoder
package avfr_pkg;

  // command codes of the block
  localparam logic [7:0] AVFR_CODE_READING = 8'hf7;
  localparam logic [7:0] AVFR_CODE_OV_REACT = 8'hf8;
  localparam logic [7:0] AVFR_CODE_UV_REACT = 8'hf9;

  // reset value of both reaction registers: immediate shutdown, no retry
  localparam logic [7:0] AVFR_REACT_RESET = 8'h80;
  localparam logic [15:0] AVFR_READING_RESET = 16'h0000;

  // field positions inside a reaction byte
  localparam int AVFR_RESP_HI = 7;
  localparam int AVFR_RESP_LO = 6;
  localparam int AVFR_RETRY_HI = 5;
  localparam int AVFR_RETRY_LO = 3;

  // response and retry encodings
  localparam logic [1:0] AVFR_RESP_SHUTDOWN = 2'h2;
  localparam logic [1:0] AVFR_RESP_HOLD = 2'h3;
  localparam logic [2:0] AVFR_RETRY_NONE = 3'h0;
  localparam logic [2:0] AVFR_RETRY_CONT = 3'h7;

  // linear-11 layout: exponent on top, mantissa below
  localparam int AVFR_EXP_W = 5;
  localparam int AVFR_MANT_W = 11;
  localparam int AVFR_MANT_LIMIT = 1024;
  // pin input lsb is 2^-12 V; the monitored quantity is 16x the pin
  localparam int AVFR_PIN_EXP = -12;
  localparam int AVFR_PIN_GAIN_SHIFT = 4;

  // warning thresholds as fractions of the fault limits
  localparam int AVFR_OV_WARN_NUM = 9;
  localparam int AVFR_UV_WARN_NUM = 11;
  localparam int AVFR_WARN_DEN = 10;

  // restart interval
  localparam int AVFR_CLK_HZ = 25_000_000;
  localparam int AVFR_RETRY_UNIT_MS = 70;
  localparam int AVFR_RETRY_UNIT_CYCLES =
    (AVFR_CLK_HZ / 1000) * AVFR_RETRY_UNIT_MS;

  // output control states
  typedef enum logic [4:0] {
    AVFR_ST_STOP  = 5'h01,
    AVFR_ST_RUN   = 5'h02,
    AVFR_ST_LATCH = 5'h04,
    AVFR_ST_HOLD  = 5'h08,
    AVFR_ST_RETRY = 5'h10
  } avfr_state_t;

endpackage
